//--- src/pdc_nvm_mem.sv
`timescale 1ns/10ps
`default_nettype none
// image of the non-volatile store; read data come out of a register
module pdc_nvm_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter logic [WIDTH*DEPTH-1:0] INIT = '0
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [AW-1:0] addr,
	output logic [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] rdata_d;

	always_comb begin
		rdata_d = INIT[addr*WIDTH +: WIDTH];
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rdata_q <= '0;
		end else begin
			rdata_q <= rdata_d;
		end
	end
endmodule
`default_nettype wire

//--- src/pdc_pkg.sv
package pdc_pkg;
	// register indices: printed offsets; the APB byte address of low index i is 4*i
	localparam int IDX_W = 16;
	localparam logic [IDX_W-1:0] IDX_DEVICE_CTRL = 16'h001E;
	localparam logic [IDX_W-1:0] IDX_DRV_0A = 16'h0103;
	localparam logic [IDX_W-1:0] IDX_DRV_0 = 16'h0108;
	localparam logic [IDX_W-1:0] IDX_DRV_1 = 16'h010D;
	localparam logic [IDX_W-1:0] IDX_DRV_2 = 16'h0112;
	localparam logic [IDX_W-1:0] IDX_DRV_3 = 16'h0117;
	localparam logic [IDX_W-1:0] IDX_DRV_4 = 16'h011C;
	localparam logic [IDX_W-1:0] IDX_DRV_5 = 16'h0121;
	localparam logic [IDX_W-1:0] IDX_DRV_6 = 16'h0126;
	localparam logic [IDX_W-1:0] IDX_DRV_7 = 16'h012B;
	localparam logic [IDX_W-1:0] IDX_DRV_8 = 16'h0130;
	localparam logic [IDX_W-1:0] IDX_DRV_9 = 16'h0135;
	localparam logic [IDX_W-1:0] IDX_DRV_9A = 16'h013A;
	localparam logic [IDX_W-1:0] IDX_ALL_DRV = 16'h0145;
	localparam logic [IDX_W-1:0] IDX_REF_OSC = 16'h090E;
	localparam logic [IDX_W-1:0] IDX_IN_BUF = 16'h0949;
	// page select sits at this low index on every page
	localparam logic [7:0] LOW_PAGE_SEL = 8'h01;

	localparam int NUM_DRV = 12;
	localparam int NUM_IN = 4;
	localparam int NUM_SLOT = 16;
	localparam int SLOT_W = 4;
	localparam int REG_W = 8;
	localparam int PAGE_W = 8;

	// slot numbering of the register bank and of the non-volatile image
	localparam logic [SLOT_W-1:0] SLOT_DEVICE = 4'h0;
	localparam logic [SLOT_W-1:0] SLOT_DRV_FIRST = 4'h1;
	localparam logic [SLOT_W-1:0] SLOT_ALL_DRV = 4'hD;
	localparam logic [SLOT_W-1:0] SLOT_REF_OSC = 4'hE;
	localparam logic [SLOT_W-1:0] SLOT_IN_BUF = 4'hF;

	// field positions
	localparam int BIT_DEV_PDN = 0;
	localparam int BIT_HARD_RST = 1;
	localparam int BIT_DRV_OFF = 0;
	localparam int BIT_ALL_OFF = 0;
	localparam int BIT_EXT_REF = 0;
	localparam int BIT_OSC_PWR = 1;
	localparam int IN_EN_LSB = 0;

	// storable bits per slot; everything else reads zero
	localparam logic [REG_W-1:0] MASK_DEVICE = 8'h01;
	localparam logic [REG_W-1:0] MASK_DRV = 8'h01;
	localparam logic [REG_W-1:0] MASK_ALL_DRV = 8'h01;
	localparam logic [REG_W-1:0] MASK_REF_OSC = 8'h03;
	localparam logic [REG_W-1:0] MASK_IN_BUF = 8'h0F;

	// reset values
	localparam logic [REG_W-1:0] RST_DEVICE = 8'h00;
	localparam logic [REG_W-1:0] RST_DRV = 8'h00;
	localparam logic [REG_W-1:0] RST_ALL_DRV = 8'h00;
	localparam logic [REG_W-1:0] RST_REF_OSC = 8'h02;
	localparam logic [REG_W-1:0] RST_IN_BUF = 8'h0F;
	localparam logic [PAGE_W-1:0] RST_PAGE = 8'h00;

	// default non-volatile image, slot 0 in the low byte
	localparam logic [NUM_SLOT*REG_W-1:0] NVM_DEFAULT = {RST_IN_BUF, RST_REF_OSC, RST_ALL_DRV,
		{NUM_DRV{RST_DRV}}, RST_DEVICE};

	typedef enum logic [1:0] {
		PDC_IDLE,
		PDC_LOAD,
		PDC_ALIGN
	} pdc_state_t;
endpackage

//--- src/pdc_powerdown_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - device_powerdown bit 1 enters low-current powerdown; 0 is normal and the default.
// - APB and all registers keep working for reads and writes during powerdown.
// - twelve drivers, each with an off bit at bit 0; 1 powers down, default 0.
// - a powered-down driver releases its pins and enables a weak pull-down.
// - all_drivers_off set powers down every driver regardless of individual bits.
// - internal_osc_power 0 powers the oscillator down; 1 is the default.
// - four input buffer enables, one per input; 0 powers down, 1 enables.
// - hard-reset bit or low reset_pin_n realigns the output clocks.
// - hard reset reloads every bank register from the non-volatile image and resets the page register to 0x00.
// - external_ref_select 0 picks crystal, oscillator as internal_osc_power sets; 1 external, oscillator off.
// - page register at low index 0x01 on every page reads and selects the page.
module pdc_powerdown_ctrl #(
	parameter int ADDR_W = 10,
	parameter logic [pdc_pkg::NUM_SLOT*pdc_pkg::REG_W-1:0] NVM_IMAGE = pdc_pkg::NVM_DEFAULT
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic reset_pin_n,
	output logic device_powerdown,
	output logic [pdc_pkg::NUM_DRV-1:0] drv_off,
	output logic [pdc_pkg::NUM_DRV-1:0] drv_oe,
	output logic [pdc_pkg::NUM_DRV-1:0] drv_weak_pulldown,
	output logic internal_osc_power,
	output logic external_ref_select,
	output logic [pdc_pkg::NUM_IN-1:0] in_buf_en,
	output logic clocks_realign,
	output logic reload_busy
);
	import pdc_pkg::*;

	localparam int CNT_W = SLOT_W + 1;
	localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(NUM_SLOT);

	// map a full paged index to a bank slot
	function automatic logic [SLOT_W:0] slot_of(input logic [IDX_W-1:0] idx);
		logic [SLOT_W:0] r;
		r = '0;
		case (idx)
			IDX_DEVICE_CTRL: r = {1'b1, SLOT_DEVICE};
			IDX_DRV_0A: r = {1'b1, 4'h1};
			IDX_DRV_0: r = {1'b1, 4'h2};
			IDX_DRV_1: r = {1'b1, 4'h3};
			IDX_DRV_2: r = {1'b1, 4'h4};
			IDX_DRV_3: r = {1'b1, 4'h5};
			IDX_DRV_4: r = {1'b1, 4'h6};
			IDX_DRV_5: r = {1'b1, 4'h7};
			IDX_DRV_6: r = {1'b1, 4'h8};
			IDX_DRV_7: r = {1'b1, 4'h9};
			IDX_DRV_8: r = {1'b1, 4'hA};
			IDX_DRV_9: r = {1'b1, 4'hB};
			IDX_DRV_9A: r = {1'b1, 4'hC};
			IDX_ALL_DRV: r = {1'b1, SLOT_ALL_DRV};
			IDX_REF_OSC: r = {1'b1, SLOT_REF_OSC};
			IDX_IN_BUF: r = {1'b1, SLOT_IN_BUF};
			default: r = '0;
		endcase
		return r;
	endfunction

	function automatic logic [REG_W-1:0] mask_of(input logic [SLOT_W-1:0] s);
		logic [REG_W-1:0] m;
		m = MASK_DRV;
		if (s == SLOT_DEVICE) begin
			m = MASK_DEVICE;
		end else if (s == SLOT_ALL_DRV) begin
			m = MASK_ALL_DRV;
		end else if (s == SLOT_REF_OSC) begin
			m = MASK_REF_OSC;
		end else if (s == SLOT_IN_BUF) begin
			m = MASK_IN_BUF;
		end
		return m;
	endfunction

	pdc_state_t state_q, state_d;
	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic [REG_W-1:0] bank_q [NUM_SLOT];
	logic [REG_W-1:0] bank_d [NUM_SLOT];
	logic [PAGE_W-1:0] page_q, page_d;
	logic ack_q, ack_d;
	logic err_q, err_d;
	logic [REG_W-1:0] rdata_q, rdata_d;
	logic [REG_W-1:0] nvm_rdata;
	logic [SLOT_W-1:0] nvm_addr;
	logic [IDX_W-1:0] full_idx;
	logic [SLOT_W:0] hit;
	logic is_page;
	logic wr_done;
	logic hard_req;

	logic dev_pdn_q, dev_pdn_d;
	logic [NUM_DRV-1:0] off_q, off_d;
	logic osc_q, osc_d;
	logic ext_q, ext_d;
	logic [NUM_IN-1:0] inen_q, inen_d;
	logic align_q, align_d;

	pdc_nvm_mem #(
		.WIDTH(REG_W),
		.DEPTH(NUM_SLOT),
		.AW(SLOT_W),
		.INIT(NVM_IMAGE)
	) u_nvm (
		.clk(clk),
		.rst(rst),
		.addr(nvm_addr),
		.rdata_q(nvm_rdata)
	);

	assign full_idx = {page_q, paddr[ADDR_W-1:2]};
	assign is_page = (paddr[ADDR_W-1:2] == LOW_PAGE_SEL);
	assign hit = slot_of(full_idx);
	assign wr_done = psel && penable && ack_q && pwrite;
	assign nvm_addr = cnt_q[SLOT_W-1:0];
	assign hard_req = (wr_done && hit[SLOT_W] && hit[SLOT_W-1:0] == SLOT_DEVICE && !is_page
		&& pwdata[BIT_HARD_RST]) || !reset_pin_n;

	// bus, bank and reload sequencing
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		page_d = page_q;
		bank_d = bank_q;
		// answer one cycle into the access phase, never while reloading
		ack_d = psel && penable && !ack_q && state_q == PDC_IDLE && reset_pin_n;
		err_d = 1'b0;
		rdata_d = rdata_q;
		if (ack_d) begin
			err_d = !is_page && !hit[SLOT_W];
			rdata_d = '0;
			if (is_page) begin
				rdata_d = page_q;
			end else if (hit[SLOT_W]) begin
				rdata_d = bank_q[hit[SLOT_W-1:0]];
			end
		end
		if (wr_done && is_page) begin
			page_d = pwdata[PAGE_W-1:0];
		end else if (wr_done && hit[SLOT_W]) begin
			bank_d[hit[SLOT_W-1:0]] = pwdata[REG_W-1:0] & mask_of(hit[SLOT_W-1:0]);
		end
		case (state_q)
			PDC_IDLE: begin
				if (hard_req) begin
					state_d = PDC_LOAD;
					cnt_d = '0;
				end
			end
			PDC_LOAD: begin
				// image data lag the address by one cycle
				if (cnt_q != '0) begin
					bank_d[cnt_q[SLOT_W-1:0] - 4'h1] = nvm_rdata & mask_of(cnt_q[SLOT_W-1:0] - 4'h1);
				end
				if (cnt_q == CNT_LAST) begin
					bank_d[SLOT_IN_BUF] = nvm_rdata & MASK_IN_BUF;
					page_d = RST_PAGE;
					state_d = PDC_ALIGN;
				end else begin
					cnt_d = cnt_q + 1'b1;
				end
			end
			PDC_ALIGN: begin
				// a pin still held low keeps restarting the reload
				state_d = reset_pin_n ? PDC_IDLE : PDC_LOAD;
				cnt_d = '0;
			end
			default: begin
				state_d = PDC_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= PDC_IDLE;
			cnt_q <= '0;
			page_q <= RST_PAGE;
			ack_q <= 1'b0;
			err_q <= 1'b0;
			rdata_q <= '0;
			bank_q[SLOT_DEVICE] <= RST_DEVICE;
			for (int i = 1; i <= NUM_DRV; i++) begin
				bank_q[i] <= RST_DRV;
			end
			bank_q[SLOT_ALL_DRV] <= RST_ALL_DRV;
			bank_q[SLOT_REF_OSC] <= RST_REF_OSC;
			bank_q[SLOT_IN_BUF] <= RST_IN_BUF;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			page_q <= page_d;
			ack_q <= ack_d;
			err_q <= err_d;
			rdata_q <= rdata_d;
			bank_q <= bank_d;
		end
	end

	// hard-reset bit is not stored and always reads back as zero
	assign prdata = {24'h000000, rdata_q};
	assign pready = ack_q;
	assign pslverr = ack_q && err_q;

	// power controls out of the bank
	always_comb begin
		dev_pdn_d = bank_q[SLOT_DEVICE][BIT_DEV_PDN];
		for (int i = 0; i < NUM_DRV; i++) begin
			off_d[i] = bank_q[i + 1][BIT_DRV_OFF] || bank_q[SLOT_ALL_DRV][BIT_ALL_OFF];
		end
		// a powered-down device also idles its oscillator
		osc_d = bank_q[SLOT_REF_OSC][BIT_OSC_PWR] && !bank_q[SLOT_REF_OSC][BIT_EXT_REF]
			&& !bank_q[SLOT_DEVICE][BIT_DEV_PDN];
		ext_d = bank_q[SLOT_REF_OSC][BIT_EXT_REF];
		inen_d = bank_q[SLOT_IN_BUF][IN_EN_LSB +: NUM_IN];
		align_d = state_q == PDC_ALIGN;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dev_pdn_q <= RST_DEVICE[BIT_DEV_PDN];
			off_q <= '0;
			osc_q <= RST_REF_OSC[BIT_OSC_PWR];
			ext_q <= RST_REF_OSC[BIT_EXT_REF];
			inen_q <= RST_IN_BUF[IN_EN_LSB +: NUM_IN];
			align_q <= 1'b0;
		end else begin
			dev_pdn_q <= dev_pdn_d;
			off_q <= off_d;
			osc_q <= osc_d;
			ext_q <= ext_d;
			inen_q <= inen_d;
			align_q <= align_d;
		end
	end

	assign device_powerdown = dev_pdn_q;
	assign drv_off = off_q;
	assign drv_oe = ~off_q;
	assign drv_weak_pulldown = off_q;
	assign internal_osc_power = osc_q;
	assign external_ref_select = ext_q;
	assign in_buf_en = inen_q;
	assign clocks_realign = align_q;
	assign reload_busy = state_q != PDC_IDLE;
endmodule
`default_nettype wire

//--- tb/pdc_powerdown_ctrl_properties.sv
`timescale 1ns/10ps
`default_nettype none
module pdc_powerdown_ctrl_properties (
	input wire logic clk,
	input wire logic rst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic reset_pin_n,
	input wire logic device_powerdown,
	input wire logic [pdc_pkg::NUM_DRV-1:0] drv_off,
	input wire logic [pdc_pkg::NUM_DRV-1:0] drv_oe,
	input wire logic [pdc_pkg::NUM_DRV-1:0] drv_weak_pulldown,
	input wire logic internal_osc_power,
	input wire logic external_ref_select,
	input wire logic clocks_realign,
	input wire logic reload_busy
);
	import pdc_pkg::*;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_pin_req;
		$fell(reset_pin_n);
	endsequence
	sequence s_reload_end;
		$fell(reload_busy);
	endsequence
	a_oe_inverse: assert property (drv_oe == ~drv_off)
		else $error("driver enable is not the inverse of off");
	a_pulldown_follows: assert property (drv_weak_pulldown == drv_off)
		else $error("weak pull-down does not follow off");
	a_pdown_osc_off: assert property (device_powerdown |-> !internal_osc_power)
		else $error("oscillator powered during powerdown");
	a_ext_osc_off: assert property (external_ref_select |-> !internal_osc_power)
		else $error("oscillator powered with external reference");
	a_pin_reload: assert property (s_pin_req |-> ##[1:3] reload_busy)
		else $error("reset pin did not start a reload");
	a_realign_after: assert property (s_reload_end |-> ##[0:2] clocks_realign)
		else $error("no realign pulse after reload");
	a_realign_pulse: assert property (clocks_realign |=> !clocks_realign)
		else $error("realign pulse longer than one cycle");
	a_busy_stall: assert property (reload_busy && $past(reload_busy) |-> !pready)
		else $error("bus answered during reload");
	a_ready_single: assert property (pready |=> !pready)
		else $error("ready held over two cycles");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	a_err_ready: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import pdc_pkg::*;
	logic clk, rst, psel, penable, pwrite, reset_pin_n, pready, pslverr, err;
	logic device_powerdown, internal_osc_power, external_ref_select, clocks_realign, reload_busy;
	logic [9:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [NUM_DRV-1:0] drv_off, drv_oe, drv_weak_pulldown;
	logic [NUM_IN-1:0] in_buf_en;
	logic [7:0] page, rd;
	int bad_count, checks;
	logic [15:0] ridx [16] = '{IDX_DEVICE_CTRL, IDX_DRV_0A, IDX_DRV_0, IDX_DRV_1, IDX_DRV_2, IDX_DRV_3,
		IDX_DRV_4, IDX_DRV_5, IDX_DRV_6, IDX_DRV_7, IDX_DRV_8, IDX_DRV_9, IDX_DRV_9A, IDX_ALL_DRV,
		IDX_REF_OSC, IDX_IN_BUF};
	pdc_powerdown_ctrl i_pdc_powerdown_ctrl (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .reset_pin_n, .device_powerdown, .drv_off, .drv_oe,
		.drv_weak_pulldown, .internal_osc_power, .external_ref_select, .in_buf_en, .clocks_realign,
		.reload_busy);
	always #2.5 clk = ~clk;
	// wide enough for the 36-bit driver compare; narrower values are zero-extended on both sides
	task chk(input logic [63:0] seen, input logic [63:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task apb(input logic we, input logic [7:0] low, input logic [7:0] wd);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= we;
		paddr <= {low, 2'b00};
		pwdata <= {24'h000000, wd};
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		chk(n < 100, 1'b1);
		rd = prdata[7:0];
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// page register is written only when the page really changes
	task acc(input logic we, input logic [15:0] idx, input logic [7:0] wd);
		if (idx[15:8] !== page) begin
			apb(1'b1, LOW_PAGE_SEL, idx[15:8]);
			page = idx[15:8];
		end
		apb(we, idx[7:0], wd);
	endtask
	// outputs land one cycle after the write edge
	task settle;
		repeat (2) @(posedge clk);
		#1;
	endtask
	task wait_realign;
		int n;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (clocks_realign !== 1'b1 && n < 200);
		chk(n < 200, 1'b1);
		page = 8'h00;
		settle;
	endtask
	task t_reset;
		for (int i = 0; i < 16; i++) begin
			acc(1'b0, ridx[i], 8'h00);
			chk({err, rd}, {1'b0, (i == 14) ? 8'h02 : (i == 15) ? 8'h0F : 8'h00});
		end
		chk({drv_oe, in_buf_en, internal_osc_power, external_ref_select}, {12'hFFF, 4'hF, 2'b10});
		acc(1'b0, {page, LOW_PAGE_SEL}, 8'h00);
		chk(rd, 8'h09);
		$display("test reset done");
	endtask
	task t_drivers;
		for (int i = 0; i < NUM_DRV; i++) begin
			acc(1'b1, ridx[i+1], 8'hFF);
			settle;
			chk({drv_off, drv_weak_pulldown, drv_oe}, {12'h001 << i, 12'h001 << i, ~(12'h001 << i)});
			acc(1'b0, ridx[i+1], 8'h00);
			chk(rd, 8'h01);
			acc(1'b1, ridx[i+1], 8'h00);
		end
		acc(1'b1, IDX_ALL_DRV, 8'h01);
		settle;
		chk({drv_off, drv_oe}, {12'hFFF, 12'h000});
		acc(1'b1, IDX_ALL_DRV, 8'h00);
		settle;
		chk(drv_off, 12'h000);
		$display("test drivers done");
	endtask
	task t_osc;
		acc(1'b1, IDX_REF_OSC, 8'h00);
		settle;
		chk({internal_osc_power, external_ref_select}, 2'b00);
		acc(1'b1, IDX_REF_OSC, 8'h03);
		settle;
		chk({internal_osc_power, external_ref_select}, 2'b01);
		acc(1'b1, IDX_IN_BUF, 8'hA5);
		acc(1'b1, IDX_REF_OSC, 8'h02);
		settle;
		chk({in_buf_en, internal_osc_power, external_ref_select}, {4'h5, 2'b10});
		$display("test oscillator done");
	endtask
	task t_pdown;
		acc(1'b1, IDX_DEVICE_CTRL, 8'h01);
		settle;
		chk({device_powerdown, internal_osc_power}, 2'b10);
		acc(1'b1, IDX_IN_BUF, 8'h0C);
		acc(1'b0, IDX_IN_BUF, 8'h00);
		settle;
		chk({rd, in_buf_en}, {8'h0C, 4'hC});
		acc(1'b1, IDX_DEVICE_CTRL, 8'h00);
		settle;
		chk({device_powerdown, internal_osc_power}, 2'b01);
		acc(1'b0, 16'h0020, 8'h00);
		chk({err, rd}, {1'b1, 8'h00});
		$display("test powerdown done");
	endtask
	task t_hard;
		acc(1'b1, IDX_DRV_3, 8'h01);
		acc(1'b1, IDX_DEVICE_CTRL, 8'h02);
		wait_realign;
		chk(drv_off, 12'h000);
		acc(1'b0, {page, LOW_PAGE_SEL}, 8'h00);
		chk(rd, 8'h00);
		acc(1'b0, IDX_DRV_3, 8'h00);
		chk(rd, 8'h00);
		acc(1'b1, IDX_IN_BUF, 8'h03);
		@(posedge clk);
		reset_pin_n <= 1'b0;
		repeat (3) @(posedge clk);
		reset_pin_n <= 1'b1;
		wait_realign;
		chk(in_buf_en, 4'hF);
		$display("test hard reset done");
	endtask
	task wrap_up;
		$display("comparisons %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	initial begin
		#200us;
		bad_count++;
		wrap_up;
	end
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		reset_pin_n = 1'b1;
		page = 8'h00;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_reset;
		t_drivers;
		t_osc;
		t_pdown;
		t_hard;
		wrap_up;
	end
endmodule
bind pdc_powerdown_ctrl pdc_powerdown_ctrl_properties i_pdc_powerdown_ctrl_properties (.clk, .rst, .psel,
	.penable, .pready, .pslverr, .reset_pin_n, .device_powerdown, .drv_off, .drv_oe, .drv_weak_pulldown,
	.internal_osc_power, .external_ref_select, .clocks_realign, .reload_busy);
`default_nettype wire
